// *** cocc_regs.vh ***
/*
 Register addresses, field positions, reset values and path timing for the
 clock output channel configuration block. Assumes inclusion by bare name.
*/
`ifndef COCC_REGS_VH
`define COCC_REGS_VH

`define COCC_WORD_W 32
`define COCC_ADDR_W 4
`define COCC_ADDR_MSB 3
`define COCC_NUM_CH 8
`define COCC_ADDR_SWING 4'h9
`define COCC_ADDR_LDP 4'hb
`define COCC_ADDR_TUNE 4'h8
`define COCC_RESET_BIT 31
`define COCC_MUX_MSB 18
`define COCC_MUX_LSB 17
`define COCC_EN_BIT 16
`define COCC_DIV_MSB 15
`define COCC_DIV_LSB 8
`define COCC_DLY_MSB 7
`define COCC_DLY_LSB 4
`define COCC_BOOST_BIT 16
`define COCC_LDP_BIT 15
`define COCC_MUX_RST 2'h0
`define COCC_DIV_RST 8'h01
`define COCC_DLY_RST 4'h0
`define COCC_MUX_BYPASS 2'h0
`define COCC_MUX_DIV 2'h1
`define COCC_MUX_DLY 2'h2
`define COCC_MUX_DIVDLY 2'h3
`define COCC_LAT_DIV_PS 16'h0064
`define COCC_LAT_DLY_PS 16'h0190
`define COCC_LAT_DIVDLY_PS 16'h01f4
`define COCC_DLY_STEP_PS 16'h0096
`define COCC_LDP_FACTOR 3'h4

`endif

// *** cocc_channel_config.v ***
/*
 Configuration logic for eight clock output channels: a three-wire serial
 write port, per-channel words, swing boost and lock-detect prescale bits.
 Assumes the serial pins and global enable pin are synchronous to clk and
 that the host keeps its own programming order.
*/
// Overview of operation
// - Eight channel words, word k controls channel k
// - Reset bit restores defaults, discards that write
// - Path select: bypass, divided, delayed, both
// - Path latency 100, 400, 500 ps extra
// - Divider active only in divided modes
// - Divide code gives twice value, 2 to 510
// - Total divide is VCO divide times channel
// - Delay active only in delayed modes
// - Delay 150 ps per code step
// - Output needs enable bit, global bit, pin
// - Power-on: bypassed, disabled, divide 1, delay 0
// - Swing boost defaults zero, raises all outputs
// - 32-bit word, low 4 bits address
// - MSB first shift, load strobe rising commits
// - Prescale divides lock detect frequency by 4
`include "cocc_regs.vh"

module cocc_channel_config #(
  parameter NUM_CH = `COCC_NUM_CH,
  parameter VCO_DIV_W = 4
)(
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Serial write port
  input wire serial_shift_clock,
  input wire serial_data,
  input wire load_strobe,
  // Global gating
  input wire global_enable_pin,
  input wire all_outputs_enable,
  // Shared VCO divide value
  input wire [VCO_DIV_W-1:0] vco_divide_value,
  // Per-channel state
  output reg [NUM_CH-1:0] channel_active,
  output reg [NUM_CH-1:0] divider_in_path,
  output reg [NUM_CH-1:0] delay_in_path,
  output reg [NUM_CH*2-1:0] path_select,
  output reg [NUM_CH*9-1:0] channel_divide_ratio,
  output reg [NUM_CH*(VCO_DIV_W+9)-1:0] total_divide_ratio,
  output reg [NUM_CH*16-1:0] path_latency_ps,
  output reg [NUM_CH-1:0] divide_code_invalid,
  // Shared output controls
  output reg swing_boost,
  output reg lock_detect_prescale,
  output reg [2:0] lock_detect_divide,
  output reg tuning_word_written
);

  localparam TW = VCO_DIV_W + 9;

  reg [`COCC_WORD_W-1:0] shift_q;
  reg sck_prev_q;
  reg le_prev_q;
  reg [NUM_CH*2-1:0] mux_q;
  reg [NUM_CH-1:0] en_q;
  reg [NUM_CH*8-1:0] div_q;
  reg [NUM_CH*4-1:0] dly_q;
  reg boost_q;
  reg ldp_q;
  reg tune_q;
  // Next values of the stored bits
  reg [`COCC_WORD_W-1:0] shift_d;
  reg boost_d;
  reg ldp_d;
  reg tune_d;
  // Next values of the shared outputs
  reg swing_d;
  reg prescale_d;
  reg [2:0] ld_div_d;
  reg tuned_d;

  wire sck_rise = serial_shift_clock & ~sck_prev_q;
  wire commit = load_strobe & ~le_prev_q;
  wire [`COCC_ADDR_W-1:0] waddr = shift_q[`COCC_ADDR_MSB:0];
  wire soft_reset = commit && (waddr == {`COCC_ADDR_W{1'b0}}) && shift_q[`COCC_RESET_BIT];

  // Mode decode used for both path stages
  function has_div;
    input [1:0] m;
    begin
      has_div = (m == `COCC_MUX_DIV) || (m == `COCC_MUX_DIVDLY);
    end
  endfunction

  function has_dly;
    input [1:0] m;
    begin
      has_dly = (m == `COCC_MUX_DLY) || (m == `COCC_MUX_DIVDLY);
    end
  endfunction

  function [15:0] fixed_lat;
    input [1:0] m;
    begin
      case (m)
        `COCC_MUX_DIV: fixed_lat = `COCC_LAT_DIV_PS;
        `COCC_MUX_DLY: fixed_lat = `COCC_LAT_DLY_PS;
        `COCC_MUX_DIVDLY: fixed_lat = `COCC_LAT_DIVDLY_PS;
        default: fixed_lat = 16'h0000;
      endcase
    end
  endfunction

  // Address match, shared by every write decode but the soft reset check
  function addr_hit;
    input [`COCC_ADDR_W-1:0] a;
    input [`COCC_ADDR_W-1:0] b;
    begin
      addr_hit = (a == b);
    end
  endfunction

  // Bits move only on a serial clock rise with the strobe low
  always @*
  begin
    shift_d = shift_q;
    if (sck_rise && !load_strobe)
    begin
      shift_d = {shift_q[`COCC_WORD_W-2:0], serial_data};
    end
  end

  // Strobe history resets to its idle high level, so release is no commit
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_q <= {`COCC_WORD_W{1'b0}};
      sck_prev_q <= 1'b0;
      le_prev_q <= 1'b1;
    end
    else
    begin
      shift_q <= shift_d;
      sck_prev_q <= serial_shift_clock;
      le_prev_q <= load_strobe;
    end
  end

  // Shared bits change only on the strobe edge
  always @*
  begin
    boost_d = boost_q;
    ldp_d = ldp_q;
    tune_d = tune_q;
    if (soft_reset)
    begin
      boost_d = 1'b0;
      ldp_d = 1'b0;
      tune_d = 1'b0;
    end
    else if (commit)
    begin
      if (addr_hit(waddr, `COCC_ADDR_SWING))
      begin
        boost_d = shift_q[`COCC_BOOST_BIT];
      end
      if (addr_hit(waddr, `COCC_ADDR_LDP))
      begin
        ldp_d = shift_q[`COCC_LDP_BIT];
      end
      if (addr_hit(waddr, `COCC_ADDR_TUNE))
      begin
        tune_d = 1'b1;
      end
    end
  end

  // Stored shared bits
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      boost_q <= 1'b0;
      ldp_q <= 1'b0;
      tune_q <= 1'b0;
    end
    else
    begin
      boost_q <= boost_d;
      ldp_q <= ldp_d;
      tune_q <= tune_d;
    end
  end

  genvar k;
  generate
    for (k = 0; k < NUM_CH; k = k + 1)
    begin : g_ch
      localparam [`COCC_ADDR_W-1:0] ADDR_K = k;
      wire [1:0] m = mux_q[2*k+1:2*k];
      wire [7:0] dv = div_q[8*k+7:8*k];
      wire [3:0] dl = dly_q[4*k+3:4*k];
      wire [8:0] ratio = {dv, 1'b0};
      wire [15:0] step = {12'h000, dl} * `COCC_DLY_STEP_PS;
      // Product width equals the output field, so no bit is lost
      wire [TW-1:0] total_div = vco_divide_value * ratio;
      wire [TW-1:0] total_byp = {{(TW-VCO_DIV_W){1'b0}}, vco_divide_value};
      // Next values of this channel's stored fields
      reg [1:0] mux_d;
      reg en_d;
      reg [7:0] div_d;
      reg [3:0] dly_d;
      // Next values of this channel's outputs
      reg active_d;
      reg div_path_d;
      reg dly_path_d;
      reg [1:0] psel_d;
      reg [8:0] ratio_d;
      reg [TW-1:0] total_d;
      reg [15:0] lat_d;
      reg invalid_d;

      // Word k belongs to channel k alone
      always @*
      begin
        mux_d = mux_q[2*k+1:2*k];
        en_d = en_q[k];
        div_d = div_q[8*k+7:8*k];
        dly_d = dly_q[4*k+3:4*k];
        if (soft_reset)
        begin
          // Rest of the reset write is dropped; reset bit is never stored
          mux_d = `COCC_MUX_RST;
          en_d = 1'b0;
          div_d = `COCC_DIV_RST;
          dly_d = `COCC_DLY_RST;
        end
        else if (commit && addr_hit(waddr, ADDR_K))
        begin
          mux_d = shift_q[`COCC_MUX_MSB:`COCC_MUX_LSB];
          en_d = shift_q[`COCC_EN_BIT];
          div_d = shift_q[`COCC_DIV_MSB:`COCC_DIV_LSB];
          dly_d = shift_q[`COCC_DLY_MSB:`COCC_DLY_LSB];
        end
      end

      // Soft reset reaches every channel through the next-value logic
      always @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          mux_q[2*k+1:2*k] <= `COCC_MUX_RST;
          en_q[k] <= 1'b0;
          div_q[8*k+7:8*k] <= `COCC_DIV_RST;
          dly_q[4*k+3:4*k] <= `COCC_DLY_RST;
        end
        else
        begin
          mux_q[2*k+1:2*k] <= mux_d;
          en_q[k] <= en_d;
          div_q[8*k+7:8*k] <= div_d;
          dly_q[4*k+3:4*k] <= dly_d;
        end
      end

      // Bypassed divider passes the clock through, a ratio of one
      always @*
      begin
        active_d = en_q[k] & all_outputs_enable & global_enable_pin;
        div_path_d = has_div(m);
        dly_path_d = has_dly(m);
        psel_d = m;
        ratio_d = has_div(m) ? ratio : 9'h001;
        total_d = has_div(m) ? total_div : total_byp;
        lat_d = fixed_lat(m) + (has_dly(m) ? step : 16'h0000);
        invalid_d = (dv == 8'h00);
      end

      // Each output is a flip-flop, one edge behind its stored field
      always @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          channel_active[k] <= 1'b0;
          divider_in_path[k] <= 1'b0;
          delay_in_path[k] <= 1'b0;
          path_select[2*k+1:2*k] <= `COCC_MUX_RST;
          channel_divide_ratio[9*k+8:9*k] <= 9'h001;
          total_divide_ratio[TW*k+TW-1:TW*k] <= {TW{1'b0}};
          path_latency_ps[16*k+15:16*k] <= 16'h0000;
          divide_code_invalid[k] <= 1'b0;
        end
        else
        begin
          channel_active[k] <= active_d;
          divider_in_path[k] <= div_path_d;
          delay_in_path[k] <= dly_path_d;
          path_select[2*k+1:2*k] <= psel_d;
          channel_divide_ratio[9*k+8:9*k] <= ratio_d;
          total_divide_ratio[TW*k+TW-1:TW*k] <= total_d;
          path_latency_ps[16*k+15:16*k] <= lat_d;
          divide_code_invalid[k] <= invalid_d;
        end
      end
    end
  endgenerate

  // Prescale choice decoded beside the stored bit
  always @*
  begin
    swing_d = boost_q;
    prescale_d = ldp_q;
    tuned_d = tune_q;
    if (ldp_q)
    begin
      ld_div_d = `COCC_LDP_FACTOR;
    end
    else
    begin
      ld_div_d = 3'h1;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      swing_boost <= 1'b0;
      lock_detect_prescale <= 1'b0;
      lock_detect_divide <= 3'h1;
      tuning_word_written <= 1'b0;
    end
    else
    begin
      swing_boost <= swing_d;
      lock_detect_prescale <= prescale_d;
      lock_detect_divide <= ld_div_d;
      tuning_word_written <= tuned_d;
    end
  end

endmodule

// *** cocc_cfg_asserts.sv ***
/*
 Checker for the channel configuration block: gating, mode decode, commit timing.
 Assumes it is bound to cocc_channel_config and sees only its ports.
*/
module cocc_cfg_asserts #(
  parameter NUM_CH = 8
)(
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Inputs watched
  input wire load_strobe,
  input wire all_outputs_enable,
  input wire global_enable_pin,
  // Outputs watched
  input wire [NUM_CH-1:0] channel_active,
  input wire [NUM_CH-1:0] divider_in_path,
  input wire [NUM_CH-1:0] delay_in_path,
  input wire [NUM_CH*2-1:0] path_select,
  input wire [NUM_CH*9-1:0] channel_divide_ratio,
  input wire [NUM_CH*16-1:0] path_latency_ps,
  input wire lock_detect_prescale,
  input wire [2:0] lock_detect_divide
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_gate_all: assert property (!$past(all_outputs_enable) |-> channel_active == 0)
    else $error("output active with global bit low");
  a_gate_pin: assert property (!$past(global_enable_pin) |-> channel_active == 0)
    else $error("output active with enable pin low");
  a_div_mode: assert property (divider_in_path[0] == path_select[0])
    else $error("divider use does not follow path select");
  a_dly_mode: assert property (delay_in_path[0] == path_select[1])
    else $error("delay use does not follow path select");
  a_ratio_bypass: assert property (!divider_in_path[0] |-> channel_divide_ratio[8:0] == 9'h001)
    else $error("bypassed divider reports a ratio");
  a_lat_bypass: assert property (path_select[1:0] == 2'h0 |-> path_latency_ps[15:0] == 16'h0000)
    else $error("bypass path shows latency");
  a_commit_only: assert property ($changed(path_select) |-> $past(load_strobe, 2) && !$past(load_strobe, 3))
    else $error("path select changed without a commit");
  a_ld_divide: assert property (lock_detect_divide == (lock_detect_prescale ? 3'h4 : 3'h1))
    else $error("lock detect divide wrong");
  cover property (channel_active != 0);
  cover property (lock_detect_divide == 3'h4);
  cover property ($rose(load_strobe));
endmodule

bind cocc_channel_config cocc_cfg_asserts #(.NUM_CH(NUM_CH)) i_chk (.clk, .resetn, .load_strobe,
  .all_outputs_enable, .global_enable_pin, .channel_active, .divider_in_path, .delay_in_path,
  .path_select, .channel_divide_ratio, .path_latency_ps, .lock_detect_prescale, .lock_detect_divide);

// *** cocc_host_model.sv ***
/*
 Host controller model: writes whole 32-bit words over the three-wire port.
 Assumes the caller waits for each send to return before the next.
*/
module cocc_host_model (
  // Clock
  input wire clk,
  // Serial write port
  output logic serial_shift_clock = 1'b0,
  output logic serial_data = 1'b0,
  output logic load_strobe = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic send(input logic [31:0] w);
    @(posedge clk);
    #1 load_strobe = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      serial_data = w[i];
      @(posedge clk);
      #1 serial_shift_clock = 1'b1;
      @(posedge clk);
      #1 serial_shift_clock = 1'b0;
    end
    // Idle data shows no stale bit, so a late sample cannot pass by luck
    serial_data = ~w[0];
    @(posedge clk);
    #1 load_strobe = 1'b1;
    @(posedge clk);
  endtask
endmodule

// *** cocc_channel_config_tb_top.sv ***
/*
 Self-checking bench for the channel configuration block.
 Assumes the host model for stimulus and the bound checker.
*/
module cocc_channel_config_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [2:0] ch; logic [1:0] m; logic [7:0] dv; logic [3:0] dl;
    logic [15:0] lat; logic [8:0] rat;} cocc_row_t;
  cocc_row_t rows [4] = '{'{3'h0, 2'h0, 8'h05, 4'h3, 16'h0000, 9'h001},
    '{3'h3, 2'h1, 8'hff, 4'h3, 16'h0064, 9'h1fe}, '{3'h5, 2'h2, 8'h02, 4'hf, 16'h0a5a, 9'h001},
    '{3'h7, 2'h3, 8'h01, 4'h1, 16'h028a, 9'h002}};
  logic clk, resetn, global_enable_pin, all_outputs_enable;
  logic [3:0] vco_divide_value;
  wire serial_shift_clock, serial_data, load_strobe, swing_boost, lock_detect_prescale;
  wire tuning_word_written;
  wire [7:0] channel_active, divider_in_path, delay_in_path, divide_code_invalid;
  wire [15:0] path_select;
  wire [71:0] channel_divide_ratio;
  wire [103:0] total_divide_ratio;
  wire [127:0] path_latency_ps;
  wire [2:0] lock_detect_divide;
  int errors = 0;
  int total_checks = 0;
  int c;
  cocc_host_model i_host (.clk, .serial_shift_clock, .serial_data, .load_strobe);
  cocc_channel_config i_dut (.clk, .resetn, .serial_shift_clock, .serial_data, .load_strobe,
    .global_enable_pin, .all_outputs_enable, .vco_divide_value, .channel_active,
    .divider_in_path, .delay_in_path, .path_select, .channel_divide_ratio, .total_divide_ratio,
    .path_latency_ps, .divide_code_invalid, .swing_boost, .lock_detect_prescale,
    .lock_detect_divide, .tuning_word_written);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] w);
    i_host.send(w);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    global_enable_pin = 1'b1;
    all_outputs_enable = 1'b1;
    vco_divide_value = 4'h3;
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    chk("ratio", 32'h1, channel_divide_ratio[8:0]);
    chk("active", 32'h0, channel_active);
    repeat (2) @(posedge clk);
    #1 chk("invalid", 32'h0, divide_code_invalid);
    chk("ld divide", 32'h1, lock_detect_divide);
    foreach (rows[k])
    begin
      wr({13'h0, rows[k].m, 1'b1, rows[k].dv, rows[k].dl, 1'b0, rows[k].ch});
      c = rows[k].ch;
      chk("mux", rows[k].m, path_select[c*2 +: 2]);
      chk("latency", rows[k].lat, path_latency_ps[c*16 +: 16]);
      chk("ratio", rows[k].rat, channel_divide_ratio[c*9 +: 9]);
      chk("div path", rows[k].m[0], divider_in_path[c]);
      chk("dly path", rows[k].m[1], delay_in_path[c]);
      chk("total", rows[k].m[0] ? vco_divide_value * rows[k].rat : vco_divide_value,
        total_divide_ratio[c*13 +: 13]);
    end
    chk("all mux", 32'hc840, path_select);
    chk("active", 32'ha9, channel_active);
    all_outputs_enable = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("gated", 32'h0, channel_active);
    all_outputs_enable = 1'b1;
    global_enable_pin = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("pin", 32'h0, channel_active);
    global_enable_pin = 1'b1;
    wr(32'h0001_800a);
    chk("unmapped", 32'h0, {swing_boost, lock_detect_prescale});
    wr(32'h0001_0009);
    chk("boost", 32'h1, swing_boost);
    wr(32'h0000_800b);
    chk("prescale", 32'h4, lock_detect_divide);
    chk("prescale bit", 32'h1, lock_detect_prescale);
    wr(32'h1000_0908);
    chk("tuning", 32'h1, tuning_word_written);
    wr(32'h0003_0003);
    chk("invalid", 32'h1, divide_code_invalid[3]);
    wr(32'h8005_ff50);
    chk("soft mux", 32'h0, path_select);
    chk("soft active", 32'h0, channel_active);
    chk("soft bits", 32'h1, {swing_boost, lock_detect_divide});
    wr(32'h0003_0150);
    chk("rewrite", 32'h2, channel_divide_ratio[8:0]);
    give_verdict();
  end
endmodule
